// ==== sim/tsm_line_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tsm_line_model #(
   parameter int BITC = 20
) (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       frameSync,
   output var  logic [7:0] tdmIn
);
   logic fsPrev_r;
   int   cyc_r;
   int   bit_r;
   // bit cell timing locked to the frame start
   always_ff @(posedge core_clk) begin
      fsPrev_r <= frameSync;
      if (sys_rst) begin
         cyc_r <= 0;
         bit_r <= 0;
      end else if (frameSync && !fsPrev_r) begin
         cyc_r <= 1;
         bit_r <= 0;
      end else if (cyc_r == BITC - 1) begin
         cyc_r <= 0;
         bit_r <= (bit_r + 1) % 256;
      end else begin
         cyc_r <= cyc_r + 1;
      end
   end
   // eight lines of 32 slots, byte = slot and line number, msb first
   always_comb begin
      for (int m = 0; m < 8; m++) begin
         tdmIn[m] = 1'({5'(bit_r / 8), 3'(m)} >> (7 - bit_r % 8));
      end
   end
endmodule : tsm_line_model
`default_nettype wire

// ==== sim/tsm_switch_matrix_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module tsm_switch_matrix_bench;
   localparam int FC = 5120;
   localparam int BC = FC / 256;
   logic        core_clk, sys_rst, avsRead, avsWrite, avsWaitRequest;
   logic        frameSync, programmableSyncOut, prbsError, en;
   logic [7:0]  avsAddress, tdmIn, tdmOut, tdmOutEn, cb, ob, sb;
   logic [31:0] avsWriteData, avsReadData;
   logic [3:0]  avsByteEnable;
   logic [31:0] expQ[$];
   int          error_cnt, cmp_count, cyc, seed, r;
   tsm_switch_matrix #(.FRAME_CYCLES(FC)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
      .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest), .tdmIn(tdmIn), .tdmOut(tdmOut), .tdmOutEn(tdmOutEn),
      .frameSync(frameSync), .programmableSyncOut(programmableSyncOut), .prbsError(prbsError));
   tsm_line_model #(.BITC(BC)) line (.core_clk(core_clk), .sys_rst(sys_rst),
      .frameSync(frameSync), .tdmIn(tdmIn));
   // compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= !wr;
      avsWriteData <= {16'h0000, d};
      avsByteEnable <= 4'hF;
      do @(posedge core_clk); while (avsWaitRequest !== 1'b0);
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      bus(1'b0, a, 16'h0000);
   endtask : rd
   task automatic ent(input logic [15:0] i, input logic [15:0] v);
      bus(1'b1, 8'h34, i);
      bus(1'b1, 8'h38, v);
   endtask : ent
   // capture one slot of a line, mid cell, with the sync output alongside
   task automatic cap(input int m, input int s, output logic [7:0] b, output logic [7:0] y);
      en = 1'b1;
      do @(posedge core_clk); while (frameSync !== 1'b0);
      do @(posedge core_clk); while (frameSync !== 1'b1);
      repeat (8 * s * BC + BC / 2 - 1) @(posedge core_clk);
      for (int j = 0; j < 8; j++) begin
         b[7 - j] = tdmOut[m];
         y[7 - j] = programmableSyncOut;
         en = en & tdmOutEn[m];
         repeat (BC) @(posedge core_clk);
      end
   endtask : cap
   task automatic close_out;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = !core_clk;
   end
   // read data watcher takes the oldest note
   always @(posedge core_clk) begin
      if (avsRead === 1'b1 && avsWaitRequest === 1'b0) begin
         if (expQ.size() == 0) chk(avsReadData, 32'hFFFFFFFF);
         else chk(avsReadData, expQ.pop_front());
      end
   end
   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 90000) begin
         error_cnt++;
         $display("[FAIL] %0t timeout", $time);
         close_out();
      end
   end
   initial begin
      seed = 32'hA154;
      sys_rst = 1'b1;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsAddress = 8'h00;
      avsWriteData = 32'h00000000;
      avsByteEnable = 4'h0;
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(8'h30, 32'h00000000);
      bus(1'b1, 8'h30, 16'h0011);
      rd(8'h30, 32'h00000011);
      rd(8'h44, 32'h00000000);
      chk({31'h0, prbsError}, 32'h0);
      r = $random(seed);
      cb = r[7:0];
      ent(16'h0034, 16'h2005);
      rd(8'h38, 32'h00000000);
      ent(16'h0047, 16'h0105);
      ent(16'h0061, {8'h84, cb});
      ent(16'h0089, 16'h4000);
      ent(16'h00CC, 16'h065A);
      repeat (2 * FC) @(posedge core_clk);
      chk({31'h0, prbsError}, 32'h1);
      bus(1'b1, 8'h34, 16'h0061);
      rd(8'h38, {16'h0000, 8'h84, cb});
      bus(1'b1, 8'h34, 16'h0105);
      rd(8'h38, 32'h00000028);
      bus(1'b1, 8'h34, 16'h01CC);
      rd(8'h38, 32'h0000005A);
      cap(1, 20, ob, sb);
      chk({24'h0, ob}, 32'h28);
      chk({31'h0, en}, 32'h1);
      cap(2, 7, ob, sb);
      chk({24'h0, ob}, 32'h28);
      cap(3, 1, ob, sb);
      chk({24'h0, ob}, {24'h0, cb});
      cap(4, 9, ob, sb);
      chk({31'h0, en}, 32'h0);
      cap(6, 12, ob, sb);
      chk({24'h0, ob}, 32'h5A);
      chk({24'h0, sb}, 32'h40);
      close_out();
   end
endmodule : tsm_switch_matrix_bench
`default_nettype wire

// ==== sim/tsm_switch_matrix_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module tsm_switch_matrix_monitor #(
   parameter int FRAME_CYCLES = 31250
) (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic [7:0]  avsAddress,
   input wire logic        avsRead,
   input wire logic        avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0]  avsByteEnable,
   input wire logic [31:0] avsReadData,
   input wire logic        avsWaitRequest,
   input wire logic [7:0]  tdmIn,
   input wire logic [7:0]  tdmOut,
   input wire logic [7:0]  tdmOutEn,
   input wire logic        frameSync,
   input wire logic        programmableSyncOut,
   input wire logic        prbsError
);
   localparam int BITC1 = FRAME_CYCLES / 256 - 1;
   localparam int FLEN1 = FRAME_CYCLES / 256 * 256 - 1;
   logic        fsPrev_r;
   logic        seen_r;
   logic [15:0] fsCnt_r;
   logic        rise;
   assign rise = frameSync && !fsPrev_r;
   // cycles since the last frame start
   always_ff @(posedge core_clk) begin
      fsPrev_r <= sys_rst ? 1'b0 : frameSync;
      seen_r   <= sys_rst ? 1'b0 : (seen_r | rise);
      fsCnt_r  <= (sys_rst || rise) ? 16'h0000 : fsCnt_r + 16'h0001;
   end
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // line outputs hold for eight cycles after each change
   sequence s_outHold; $stable(tdmOut)[*8]; endsequence
   sequence s_enHold; $stable(tdmOutEn)[*8]; endsequence
   sequence s_syHold; $stable(programmableSyncOut)[*8]; endsequence
   property p_readAns; avsRead && avsWaitRequest |=> !avsWaitRequest; endproperty
   property p_wrAns;
      avsWrite && avsWaitRequest && avsAddress != 8'h38 |=> !avsWaitRequest;
   endproperty
   property p_oneLow; !avsWaitRequest |=> avsWaitRequest; endproperty
   property p_hiZero;
      avsRead && !avsWaitRequest |-> avsReadData[31:16] == 16'h0000;
   endproperty
   property p_frame; rise && seen_r |-> fsCnt_r == 16'(FLEN1); endproperty
   property p_fsWidth;
      rise |-> (frameSync throughout (##BITC1 1'b1)) ##1 !frameSync;
   endproperty
   property p_outHold; $changed(tdmOut) |=> s_outHold; endproperty
   property p_enHold; $changed(tdmOutEn) |=> s_enHold; endproperty
   property p_syHold; $changed(programmableSyncOut) |=> s_syHold; endproperty
   a_readAns: assert property (p_readAns) else $error("read not answered");
   a_wrAns: assert property (p_wrAns) else $error("write not answered");
   a_oneLow: assert property (p_oneLow) else $error("waitrequest low too long");
   a_hiZero: assert property (p_hiZero) else $error("read data upper bits set");
   a_frame: assert property (p_frame) else $error("frame length wrong");
   a_fsWidth: assert property (p_fsWidth) else $error("frame sync width wrong");
   a_outHold: assert property (p_outHold) else $error("line output glitch");
   a_enHold: assert property (p_enHold) else $error("enable glitch");
   a_syHold: assert property (p_syHold) else $error("sync output glitch");
endmodule : tsm_switch_matrix_monitor
bind tsm_switch_matrix tsm_switch_matrix_monitor #(.FRAME_CYCLES(FRAME_CYCLES)) u_mon (
   .core_clk(core_clk), .sys_rst(sys_rst), .avsAddress(avsAddress), .avsRead(avsRead),
   .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
   .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .tdmIn(tdmIn),
   .tdmOut(tdmOut), .tdmOutEn(tdmOutEn), .frameSync(frameSync),
   .programmableSyncOut(programmableSyncOut), .prbsError(prbsError));
`default_nettype wire

// ==== src/tsm_map.svh ====
`ifndef TSM_MAP_SVH
`define TSM_MAP_SVH
// register word indices; byte address is four times the index
`define TSM_IDX_CFG     6'h0C
`define TSM_IDX_CMADDR  6'h0D
`define TSM_IDX_CMDATA  6'h0E
`define TSM_IDX_STATUS  6'h0F
// reset values
`define TSM_CFG_RESET   16'h0000
`define TSM_ADDR_RESET  9'h000
`define TSM_PRBS_SEED   15'h7FFF
// timing
`define TSM_CLK_NS      4
`define TSM_FRAME_NS    125000
`define TSM_BITS_FRAME  256
// address register: bit that selects the data memory instead of the connection memory
`define TSM_ADDR_DMSEL  8
// status bits
`define TSM_ST_ERR      0
// slot within a four-slot channel group that carries the 16 kbit/s D bits
`define TSM_D_SLOT      2'h2
`define TSM_D_FILL      6'h3F
`define TSM_IDLE_BYTE   8'hFF
`endif

// ==== src/tsm_pkg.sv ====
package tsm_pkg;
   // one connection memory entry
   typedef struct packed {
      logic       syncBit;
      logic       disc;
      logic       prbsExt;
      logic       prbsIns;
      logic       dPack;
      logic       constOut;
      logic       loop;
      logic       seqInt;
      logic [2:0] srcMux;
      logic [4:0] srcSlot;
   } tsm_cm_entry_type;
   // matrix_configuration register
   typedef struct packed {
      logic [10:0] rsvd;
      logic        extEn;
      logic        insEn;
      logic        halfRateSelectB;
      logic        halfRateSelectA;
      logic        minDelaySelect;
   } tsm_cfg_type;
   typedef enum logic {
      TSM_SEQ_IDLE = 1'b0,
      TSM_SEQ_RUN  = 1'b1
   } tsm_seq_state_type;
endpackage : tsm_pkg

// ==== src/tsm_switch_matrix.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tsm_map.svh"
module tsm_switch_matrix #(
   parameter int FRAME_CYCLES = `TSM_FRAME_NS / `TSM_CLK_NS
) (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  avsAddress,
   input  wire logic        avsRead,
   input  wire logic        avsWrite,
   input  wire logic [31:0] avsWriteData,
   input  wire logic [3:0]  avsByteEnable,
   output logic      [31:0] avsReadData,
   output logic             avsWaitRequest,
   input  wire logic [7:0]  tdmIn,
   output logic      [7:0]  tdmOut,
   output logic      [7:0]  tdmOutEn,
   output logic             frameSync,
   output logic             programmableSyncOut,
   output logic             prbsError
);
   localparam int          BIT_CYC    = FRAME_CYCLES / `TSM_BITS_FRAME;
   localparam logic [15:0] BIT_LAST   = 16'(BIT_CYC - 1);
   localparam logic [15:0] SAMPLE_CYC = 16'(BIT_CYC / 2);
   localparam logic [15:0] SEQ_START  = 16'(BIT_CYC / 2); // last mux result lands before bitEnd

   tsm_pkg::tsm_cfg_type          cfg_r;
   tsm_pkg::tsm_seq_state_type    seqState_r;
   tsm_pkg::tsm_cm_entry_type     ent;
   logic [15:0]                   cm_r [256];
   logic [7:0]                    dataBuf_r [2][256];
   logic [7:0]                    outMem_r [256];
   logic [15:0]                   bitCyc_r;
   logic [7:0]                    frameBit_r;
   logic                          parity_r;
   logic [2:0]                    seqMux_r;
   logic [7:0]                    resByte_r [8];
   logic [7:0]                    resEn_r;
   logic [7:0]                    loopSel_r;
   logic [7:0]                    loopByte_r [8];
   logic [7:0]                    rxByte [8];
   logic [7:0]                    wrByte [8];
   logic [14:0]                   prbsGen_r;
   logic [14:0]                   prbsAna_r;
   logic [8:0]                    cmAddr_r;
   logic                          pendValid_r;
   logic [7:0]                    pendIdx_r;
   logic [15:0]                   pendData_r;
   logic                          err_r;
   logic                          waitReq_r;
   logic [31:0]                   readData_r;
   logic                          frameSync_r;
   logic                          syncOut_r;
   logic [4:0]                    slot;
   logic [4:0]                    nextSlot;
   logic                          nextPar;
   logic                          sampleNow;
   logic                          bitEnd;
   logic                          seqStart;
   logic                          seqRun;
   logic [7:0]                    srcIdx;
   logic [7:0]                    curByte;
   logic [7:0]                    prevByte;
   logic [7:0]                    swByte;
   logic [7:0]                    packByte;
   logic [1:0]                    splitBits;
   logic [5:0]                    minOff;
   logic [7:0]                    seqByte;
   logic                          seqEn;
   logic                          anaMismatch;
   logic [14:0]                   genNext;
   logic [14:0]                   anaNext;
   logic                          busReq;
   logic                          blocked;
   logic                          take;
   logic                          wrCommit;
   logic [5:0]                    regIdx;
   logic                          addrOk;
   logic [15:0]                   cmMerged;

   // eight steps of x^15 + x^14 + 1 per byte
   function automatic logic [14:0] tsm_prbs8(input logic [14:0] s);
      logic [14:0] v;
      v = s;
      for (int i = 0; i < 8; i++) begin
         v = {v[13:0], v[14] ^ v[13]};
      end
      return v;
   endfunction : tsm_prbs8

   // frame timing
   assign slot      = frameBit_r[7:3];
   assign nextSlot  = slot + 5'h01;
   assign nextPar   = parity_r ^ (&slot);
   assign sampleNow = (bitCyc_r == SAMPLE_CYC);
   assign bitEnd    = (bitCyc_r == BIT_LAST);
   assign seqStart  = (&frameBit_r[2:0]) && (bitCyc_r == SEQ_START);
   assign seqRun    = (seqState_r == tsm_pkg::TSM_SEQ_RUN);

   // bit, slot and frame counters; buffer parity flips per frame
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bitCyc_r   <= 16'h0000;
         frameBit_r <= 8'h00;
         parity_r   <= 1'b0;
      end else if (bitEnd) begin
         bitCyc_r   <= 16'h0000;
         frameBit_r <= frameBit_r + 8'h01;
         if (&frameBit_r) begin
            parity_r <= ~parity_r;
         end
      end else begin
         bitCyc_r <= bitCyc_r + 16'h0001;
      end
   end

   // per multiplex serial in/out, half-rate folding and hiding
   generate
      for (genvar m = 0; m < 8; m++) begin : gMux
         localparam logic [2:0] MUX     = 3'(m);
         localparam logic [2:0] PARTNER = MUX ^ 3'h2;
         logic [6:0] inShift_r;
         logic [7:0] outShift_r;
         logic       outBit_r;
         logic       outEn_r;
         logic       halfSel;
         logic       isHalf;
         logic       hidden;
         logic [7:0] txByte;
         assign halfSel = MUX[0] ? cfg_r.halfRateSelectB : cfg_r.halfRateSelectA;
         assign isHalf  = ~MUX[1] & halfSel;
         assign hidden  = MUX[1] & halfSel;
         assign rxByte[m] = {inShift_r, tdmIn[m]};
         // loopback overrides the pin; half rate splits nibbles over the partner
         always_comb begin
            if (loopSel_r[m]) begin
               wrByte[m] = loopByte_r[m];
            end else if (hidden) begin
               wrByte[m] = {rxByte[PARTNER][3:0], 4'h0};
            end else if (isHalf) begin
               wrByte[m] = {rxByte[m][7:4], 4'h0};
            end else begin
               wrByte[m] = rxByte[m];
            end
         end
         assign txByte = isHalf ? {resByte_r[m][7:4], resByte_r[PARTNER][7:4]} : resByte_r[m];
         // input shift and output shift, msb first
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               inShift_r  <= 7'h00;
               outShift_r <= `TSM_IDLE_BYTE;
               outBit_r   <= 1'b1;
               outEn_r    <= 1'b0;
            end else begin
               if (sampleNow) begin
                  inShift_r <= rxByte[m][6:0];
               end
               if (bitEnd && (&frameBit_r[2:0])) begin
                  outShift_r <= txByte;
                  outBit_r   <= txByte[7];
                  outEn_r    <= resEn_r[m] & ~hidden;
               end else if (bitEnd) begin
                  outShift_r <= {outShift_r[6:0], 1'b1};
                  outBit_r   <= outShift_r[6];
               end
            end
         end
         assign tdmOut[m]   = outBit_r;
         assign tdmOutEn[m] = outEn_r;
      end
   endgenerate

   // input frame store into the buffer of the current parity
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 256; i++) begin
            dataBuf_r[0][i] <= 8'h00;
            dataBuf_r[1][i] <= 8'h00;
         end
      end else if (sampleNow && (&frameBit_r[2:0])) begin
         for (int m = 0; m < 8; m++) begin
            dataBuf_r[parity_r][{3'(m), slot}] <= wrByte[m];
         end
      end
   end

   // slot selection and output data for the entry being processed
   always_comb begin
      ent       = tsm_pkg::tsm_cm_entry_type'(cm_r[{seqMux_r, nextSlot}]);
      srcIdx    = {ent.srcMux, ent.srcSlot};
      curByte   = dataBuf_r[nextPar][srcIdx];
      prevByte  = dataBuf_r[~nextPar][srcIdx];
      minOff    = cfg_r.minDelaySelect ? 6'h02 : 6'h01;
      packByte  = 8'h00;
      genNext   = tsm_prbs8(prbsGen_r);
      anaNext   = tsm_prbs8(prbsAna_r);
      if (ent.seqInt) begin
         swByte = outMem_r[{seqMux_r, nextSlot}];
      end else if ({1'b0, nextSlot} > ({1'b0, ent.srcSlot} + minOff)) begin
         swByte = curByte;
      end else begin
         swByte = prevByte;
      end
      for (int i = 0; i < 4; i++) begin
         packByte[(7 - 2 * i) -: 2] =
            dataBuf_r[~nextPar][{2'b10, ent.srcSlot[1], ent.srcSlot[0], 2'(i), `TSM_D_SLOT}][7:6];
      end
      splitBits = swByte[(7 - 2 * int'(nextSlot[3:2])) -: 2];
      seqEn     = 1'b1;
      if (ent.disc) begin
         seqByte = `TSM_IDLE_BYTE;
         seqEn   = 1'b0;
      end else if (ent.constOut) begin
         seqByte = srcIdx;
      end else if (ent.prbsIns && cfg_r.insEn) begin
         seqByte = genNext[7:0];
      end else if (ent.dPack && (seqMux_r[2:1] == 2'b10)) begin
         seqByte = (nextSlot[1:0] == `TSM_D_SLOT) ? {splitBits, `TSM_D_FILL} : swByte;
      end else if (ent.dPack) begin
         seqByte = packByte;
      end else begin
         seqByte = swByte;
      end
      anaMismatch = ent.prbsExt && cfg_r.extEn && (swByte != anaNext[7:0]);
   end

   // sequencer walks the eight output multiplexes once per slot
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         seqState_r <= tsm_pkg::TSM_SEQ_IDLE;
         seqMux_r   <= 3'h0;
      end else begin
         case (seqState_r)
            tsm_pkg::TSM_SEQ_IDLE: begin
               if (seqStart) begin
                  seqState_r <= tsm_pkg::TSM_SEQ_RUN;
                  seqMux_r   <= 3'h0;
               end
            end
            tsm_pkg::TSM_SEQ_RUN: begin
               seqMux_r <= seqMux_r + 3'h1;
               if (&seqMux_r) begin
                  seqState_r <= tsm_pkg::TSM_SEQ_IDLE;
               end
            end
            default: begin
               seqState_r <= tsm_pkg::TSM_SEQ_IDLE;
            end
         endcase
      end
   end

   // per-slot results, loopback capture and output memory transfer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 8; i++) begin
            resByte_r[i]  <= `TSM_IDLE_BYTE;
            loopByte_r[i] <= 8'h00;
         end
         for (int i = 0; i < 256; i++) begin
            outMem_r[i] <= 8'h00;
         end
         resEn_r   <= 8'h00;
         loopSel_r <= 8'h00;
      end else if (seqRun) begin
         resByte_r[seqMux_r]  <= seqByte;
         resEn_r[seqMux_r]    <= seqEn;
         loopSel_r[seqMux_r]  <= ent.loop;
         loopByte_r[seqMux_r] <= seqByte;
         if (ent.seqInt) begin
            outMem_r[{seqMux_r, nextSlot}] <= prevByte;
         end
      end
   end

   // generator advances one byte per byte it inserts, analyzer one byte per marked slot
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prbsGen_r <= `TSM_PRBS_SEED;
         prbsAna_r <= `TSM_PRBS_SEED;
      end else if (seqRun) begin
         if (ent.prbsIns && cfg_r.insEn && !ent.disc && !ent.constOut) begin
            prbsGen_r <= genNext;
         end
         if (ent.prbsExt && cfg_r.extEn) begin
            prbsAna_r <= anaNext;
         end
      end
   end

   // connection memory: pending write lands only before slot 0 of a frame
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 256; i++) begin
            cm_r[i] <= 16'h0000;
         end
      end else if (seqStart && (nextSlot == 5'h00) && pendValid_r) begin
         cm_r[pendIdx_r] <= pendData_r;
      end
   end

   // sync pattern bit and frame marker, one bit per bit period
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         syncOut_r   <= 1'b0;
         frameSync_r <= 1'b0;
      end else if (bitEnd) begin
         syncOut_r   <= cm_r[frameBit_r + 8'h01][15];
         frameSync_r <= (&frameBit_r);
      end
   end

   // avalon slave decode
   assign regIdx   = avsAddress[7:2];
   assign addrOk   = (avsAddress[1:0] == 2'b00);
   assign busReq   = waitReq_r && (avsRead || avsWrite);
   assign blocked  = avsWrite && pendValid_r && addrOk && (regIdx == `TSM_IDX_CMDATA);
   assign take     = busReq && !blocked;
   assign wrCommit = !waitReq_r && avsWrite && addrOk; // write lands on the edge ending the wait
   assign cmMerged = {avsByteEnable[1] ? avsWriteData[15:8] : cm_r[cmAddr_r[7:0]][15:8],
                      avsByteEnable[0] ? avsWriteData[7:0] : cm_r[cmAddr_r[7:0]][7:0]};

   // handshake and read data; waitrequest drops one cycle after a request, except a data write waits while an entry is pending
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         waitReq_r  <= 1'b1;
         readData_r <= 32'h00000000;
      end else begin
         waitReq_r <= ~take;
         if (take && avsRead) begin
            readData_r <= 32'h00000000;
            if (addrOk) begin
               case (regIdx)
                  `TSM_IDX_CFG:    readData_r[15:0] <= cfg_r;
                  `TSM_IDX_CMADDR: readData_r[8:0]  <= cmAddr_r;
                  `TSM_IDX_CMDATA: begin
                     if (cmAddr_r[`TSM_ADDR_DMSEL]) begin
                        readData_r[7:0] <= dataBuf_r[~parity_r][cmAddr_r[7:0]];
                     end else begin
                        readData_r[15:0] <= cm_r[cmAddr_r[7:0]];
                     end
                  end
                  `TSM_IDX_STATUS: readData_r[2:0] <= {parity_r, pendValid_r, err_r};
                  default:         readData_r <= 32'h00000000;
               endcase
            end
         end
      end
   end

   // register writes; entry writes wait in the pending slot
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_r       <= `TSM_CFG_RESET;
         cmAddr_r    <= `TSM_ADDR_RESET;
         pendValid_r <= 1'b0;
         pendIdx_r   <= 8'h00;
         pendData_r  <= 16'h0000;
      end else begin
         if (seqStart && (nextSlot == 5'h00)) begin
            pendValid_r <= 1'b0;
         end
         if (wrCommit) begin
            case (regIdx)
               `TSM_IDX_CFG: begin
                  if (avsByteEnable[0]) begin
                     cfg_r[4:0] <= avsWriteData[4:0];
                  end
               end
               `TSM_IDX_CMADDR: begin
                  if (avsByteEnable[0]) begin
                     cmAddr_r[7:0] <= avsWriteData[7:0];
                  end
                  if (avsByteEnable[1]) begin
                     cmAddr_r[8] <= avsWriteData[8];
                  end
               end
               `TSM_IDX_CMDATA: begin
                  if (!cmAddr_r[`TSM_ADDR_DMSEL]) begin
                     pendValid_r <= 1'b1;
                     pendIdx_r   <= cmAddr_r[7:0];
                     pendData_r  <= cmMerged;
                  end
               end
               default: begin
                  pendIdx_r <= pendIdx_r;
               end
            endcase
         end
      end
   end

   // sticky analyzer error, write one to clear, a new mismatch wins
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         err_r <= 1'b0;
      end else if (seqRun && anaMismatch) begin
         err_r <= 1'b1;
      end else if (wrCommit && (regIdx == `TSM_IDX_STATUS) &&
                   avsByteEnable[0] && avsWriteData[`TSM_ST_ERR]) begin
         err_r <= 1'b0;
      end
   end

   assign avsReadData         = readData_r;
   assign avsWaitRequest      = waitReq_r;
   assign frameSync           = frameSync_r;
   assign programmableSyncOut = syncOut_r;
   assign prbsError           = err_r;
endmodule : tsm_switch_matrix
`default_nettype wire
